/* File: design/vbi_pkg.sv */
/*
  constants, types and the check-sequence function for the vbi inserter.
  assumes the timing generator and register port feeding it share clk.
*/
`default_nettype none
package vbi_pkg;
  // register subaddresses
  localparam logic [7:0] ADDR_EDHD_CTRL = 8'h32;
  localparam logic [7:0] ADDR_CM_PAY0   = 8'h41;
  localparam logic [7:0] ADDR_CM_PAY1   = 8'h42;
  localparam logic [7:0] ADDR_CM_PAY2   = 8'h43;
  localparam logic [7:0] ADDR_TB_FIRST  = 8'h5e;
  localparam logic [7:0] ADDR_TB_LAST   = 8'h6e;
  localparam logic [7:0] ADDR_SD_CTRL   = 8'h99;
  localparam logic [7:0] ADDR_SD_PAYA   = 8'h9a;
  localparam logic [7:0] ADDR_SD_PAYB   = 8'h9b;
  localparam logic [7:0] ADDR_SD_BLANK  = 8'ha1;
  localparam logic [7:0] REG_RESET      = 8'h00;
  localparam int TB_REGS = 17;
  // field positions
  localparam int CM_EN_BIT     = 6;
  localparam int ED_CRC_BIT    = 7;
  localparam int TB_EN_BIT     = 0;
  localparam int TB_CRC_BIT    = 1;
  localparam int SD_CRC_BIT    = 4;
  localparam int SD_ODD_BIT    = 5;
  localparam int SD_EVEN_BIT   = 6;
  localparam int WSS_EN_BIT    = 7;
  localparam int WSS_BLANK_BIT = 7;
  // line numbers
  localparam logic [10:0] LN_ED625_CM  = 11'd43;
  localparam logic [10:0] LN_720_CM    = 11'd24;
  localparam logic [10:0] LN_720_TB    = 11'd23;
  localparam logic [10:0] LN_1080_CM0  = 11'd19;
  localparam logic [10:0] LN_1080_CM1  = 11'd582;
  localparam logic [10:0] LN_1080_TB0  = 11'd18;
  localparam logic [10:0] LN_1080_TB1  = 11'd581;
  localparam logic [10:0] LN_SD_ODD    = 11'd20;
  localparam logic [10:0] LN_SD_EVEN   = 11'd283;
  localparam logic [10:0] LN_WSS       = 11'd23;
  // packet sizes and check sequence
  localparam logic [7:0] CM_BITS   = 8'd20;
  localparam logic [7:0] ED_BITS   = 8'd16;
  localparam logic [7:0] TB_BITS   = 8'd134;
  localparam logic [7:0] WSS_BITS  = 8'd38;
  localparam int         CM_LOW_W  = 14;
  localparam int         TB_LOW_W  = 128;
  localparam logic [5:0] CRC_PRESET = 6'h3f;
  localparam logic [5:0] CRC_POLY   = 6'h03;
  localparam logic [23:0] WSS_PREFIX = 24'h1e5555;   // run-in then start code
  // output levels
  localparam logic [9:0] LVL_BLANK = 10'h040;
  localparam logic [9:0] LVL_HIGH  = 10'h2d0;
  // timing
  localparam int  CLK_PERIOD_NS = 8;
  localparam real WSS_END_US    = 42.5;
  localparam int  WSS_END_CYC   = int'($ceil(WSS_END_US * 1000.0 / CLK_PERIOD_NS));
  localparam int  START_CYC     = 200;
  localparam int  BIT_CYC       = 20;

  typedef enum logic [2:0] {
    STD_SD_NTSC,
    STD_SD_PAL,
    STD_ED_525P,
    STD_ED_625P,
    STD_HD_720P,
    STD_HD_1080I
  } vbiStd_t;

  typedef struct packed {
    logic       en;
    logic [7:0] addr;
    logic [7:0] data;
  } vbiRegWr_t;

  typedef struct packed {
    logic        hsyncFall;
    logic [10:0] lineNum;
  } vbiTiming_t;

  // x^6+x+1, preset all ones, data bit 0 first; remainder bit k -> check bit k
  function automatic logic [5:0] vbi_crc6(input logic [127:0] d, input int n);
    logic [5:0] c;
    logic       fb;
    c = CRC_PRESET;
    for (int i = 0; i < 128; i++)
    begin
      if (i < n)
      begin
        fb = d[i] ^ c[5];
        c  = {c[4:0], 1'b0} ^ (fb ? CRC_POLY : 6'h00);
      end
    end
    return c;
  endfunction : vbi_crc6
endpackage : vbi_pkg
`default_nettype wire

/* File: design/vbi_inserter.sv */
/*
  copy-management and wide-screen signal inserter for the vbi lines.
  assumes a timing generator giving line numbers and an hsync-fall pulse,
  and a subaddress register port, all on clk.
*/
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// RL1 - 625p copy data on line 43 when enabled
// RL2 - 625p payload from subaddresses copy_mgmt_payload_1, copy_mgmt_payload_2
// RL3 - 720p copy data on line 24
// RL4 - 1080i copy data on lines 19, 582
// RL5 - hd payload from subaddresses copy_mgmt_payload_0 to copy_mgmt_payload_2
// RL6 - 720p type b packet on line 23
// RL7 - 1080i type b packet on lines 18, 581
// RL8 - type b packet held in type_b_packet_control..0x6e
// RL9 - crc enable computes top six bits
// RL10 - polynomial x^6+x+1, preset all ones
// RL11 - crc off sends twenty register bits
// RL12 - type b crc fills bits from 128
// RL13 - type b crc off sends 134 bits
// RL14 - wide-screen data sent on line 23
// RL15 - wide-screen only in pal output
// RL16 - 14 bits after run-in and start code
// RL17 - video resumes 42.5 us after hsync
// RL18 - wide-screen needs enable bit 7 of sd_vbi_signal_control
// RL19 - bit 7 of sd_blanking_control blanks wide-screen part
// RL20 - host codes aspect in bits 3:0
// RL21 - host sets bits 13:4 meanings
// RL22 - sd copy data lines 20, 283
// RL23 - crc shifts lsb first, ascending result
module vbi_inserter
  import vbi_pkg::*;
#(
  parameter int WSS_END = WSS_END_CYC,   // hsync fall to video resume
  parameter int LEAD    = START_CYC,     // hsync fall to first bit
  parameter int BITLEN  = BIT_CYC        // cycles per data bit
)(
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire vbiRegWr_t  regWr,
  input  wire logic [7:0] regRdAddr,
  output logic [7:0]      regRdData,
  input  wire vbiStd_t    videoStd,
  input  wire vbiTiming_t timing,
  input  wire logic [9:0] videoIn,
  output logic [9:0]      videoOut,
  output logic            insActive
);

  typedef enum {S_IDLE, S_LEAD, S_SEND, S_TAIL} vbiState_t;

  logic [7:0]   edhdCtrl_q;              // enables and crc for ed/hd
  logic [7:0]   cmPay0_q;                // c19..c16 in low nibble
  logic [7:0]   cmPay1_q;                // c15..c8
  logic [7:0]   cmPay2_q;                // c7..c0
  logic [7:0]   tb_q [TB_REGS];          // type b control and packet
  logic [7:0]   sdCtrl_q;                // sd crc, field and wss enables
  logic [7:0]   sdPayA_q;                // sd payload low byte
  logic [7:0]   sdPayB_q;                // sd payload next bits
  logic [7:0]   sdBlank_q;               // blanking control
  logic [133:0] shift_q;                 // bits leaving lsb first
  logic [7:0]   bitsLeft_q;              // bits still to send
  logic         wssLine_q;               // line holds wss window, sent or blanked
  logic         blankBits_q;             // bits replaced by blank level
  logic [15:0]  cyc_q;                   // cycles since hsync fall
  logic [15:0]  bitDiv_q;                // bit period divider
  logic         bitEn;                   // one-cycle bit enable
  vbiState_t    state_q;
  logic [19:0]  cmWord;                  // hd copy word after crc
  logic [19:0]  sdWord;                  // sd copy word after crc
  logic [15:0]  edWord;                  // 625p copy word
  logic [133:0] tbWord;                  // type b packet after crc
  logic [127:0] tbLow;                   // header and body bits
  logic [13:0]  wssWord;                 // wide-screen payload
  logic         selCm;
  logic         selEd;
  logic         selTb;
  logic         selSd;
  logic         selWss;
  logic         palWssLine;
  logic [4:0]   tbIdx;

  assign tbIdx = 5'(regWr.addr - ADDR_TB_FIRST);

  // register writes from the subaddress port
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      edhdCtrl_q <= REG_RESET;
      cmPay0_q   <= REG_RESET;
      cmPay1_q   <= REG_RESET;
      cmPay2_q   <= REG_RESET;
      sdCtrl_q   <= REG_RESET;
      sdPayA_q   <= REG_RESET;
      sdPayB_q   <= REG_RESET;
      sdBlank_q  <= REG_RESET;
      for (int i = 0; i < TB_REGS; i++)
      begin
        tb_q[i] <= REG_RESET;
      end
    end
    else if (regWr.en)
    begin
      case (regWr.addr)
        ADDR_EDHD_CTRL: edhdCtrl_q <= regWr.data;
        ADDR_CM_PAY0:   cmPay0_q   <= regWr.data;
        ADDR_CM_PAY1:   cmPay1_q   <= regWr.data;
        ADDR_CM_PAY2:   cmPay2_q   <= regWr.data;
        ADDR_SD_CTRL:   sdCtrl_q   <= regWr.data;
        ADDR_SD_PAYA:   sdPayA_q   <= regWr.data;
        ADDR_SD_PAYB:   sdPayB_q   <= regWr.data;
        ADDR_SD_BLANK:  sdBlank_q  <= regWr.data;
        default:
        begin
          // type b range; other addresses are ignored
          if (regWr.addr >= ADDR_TB_FIRST && regWr.addr <= ADDR_TB_LAST)
          begin
            tb_q[tbIdx] <= regWr.data;   // RL8
          end
        end
      endcase
    end
  end

  // registered read-back; unmapped subaddresses read zero
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      regRdData <= REG_RESET;
    end
    else
    begin
      case (regRdAddr)
        ADDR_EDHD_CTRL: regRdData <= edhdCtrl_q;
        ADDR_CM_PAY0:   regRdData <= cmPay0_q;
        ADDR_CM_PAY1:   regRdData <= cmPay1_q;
        ADDR_CM_PAY2:   regRdData <= cmPay2_q;
        ADDR_SD_CTRL:   regRdData <= sdCtrl_q;
        ADDR_SD_PAYA:   regRdData <= sdPayA_q;
        ADDR_SD_PAYB:   regRdData <= sdPayB_q;
        ADDR_SD_BLANK:  regRdData <= sdBlank_q;
        default:
        begin
          if (regRdAddr >= ADDR_TB_FIRST && regRdAddr <= ADDR_TB_LAST)
          begin
            regRdData <= tb_q[5'(regRdAddr - ADDR_TB_FIRST)];
          end
          else
          begin
            regRdData <= REG_RESET;
          end
        end
      endcase
    end
  end

  // payload assembly, with optional check sequence in the top six bits
  always_comb
  begin
    cmWord = {cmPay0_q[3:0], cmPay1_q, cmPay2_q};            // RL5 RL11
    if (edhdCtrl_q[ED_CRC_BIT])
    begin
      cmWord[19:14] = vbi_crc6(128'(cmWord[13:0]), CM_LOW_W); // RL9 RL10 RL23
    end
    sdWord = {sdCtrl_q[3:0], sdPayA_q, sdPayB_q};
    if (sdCtrl_q[SD_CRC_BIT])
    begin
      sdWord[19:14] = vbi_crc6(128'(sdWord[13:0]), CM_LOW_W); // RL9 RL10
    end
    edWord = {cmPay1_q, cmPay2_q};                             // RL2
    tbLow[5:0] = tb_q[0][7:2];
    for (int k = 1; k < TB_REGS - 1; k++)    // middle registers carry packet bits 6..125
    begin
      tbLow[8*k+5 -: 8] = tb_q[k];
    end
    tbLow[127:126] = tb_q[TB_REGS-1][1:0];   // last register: low two bits below the check bits
    tbWord = {tb_q[TB_REGS-1][7:2], tbLow};                    // RL13
    if (tb_q[0][TB_CRC_BIT])
    begin
      tbWord[133:128] = vbi_crc6(tbLow, TB_LOW_W);             // RL12 RL10 RL23
    end
    wssWord = {sdPayB_q[5:0], sdPayA_q};                       // RL16
  end

  // which insertion this line carries
  always_comb
  begin
    selCm  = 1'b0;
    selEd  = 1'b0;
    selTb  = 1'b0;
    selSd  = 1'b0;
    palWssLine = (videoStd == STD_SD_PAL) && (timing.lineNum == LN_WSS); // RL15
    selWss = palWssLine && sdCtrl_q[WSS_EN_BIT];               // RL14 RL18
    case (videoStd)
      STD_ED_625P:
      begin
        selEd = edhdCtrl_q[CM_EN_BIT] && (timing.lineNum == LN_ED625_CM); // RL1
      end
      STD_HD_720P:
      begin
        selCm = edhdCtrl_q[CM_EN_BIT] && (timing.lineNum == LN_720_CM);   // RL3
        selTb = tb_q[0][TB_EN_BIT] && (timing.lineNum == LN_720_TB);      // RL6
      end
      STD_HD_1080I:
      begin
        selCm = edhdCtrl_q[CM_EN_BIT] &&
                (timing.lineNum == LN_1080_CM0 || timing.lineNum == LN_1080_CM1); // RL4
        selTb = tb_q[0][TB_EN_BIT] &&
                (timing.lineNum == LN_1080_TB0 || timing.lineNum == LN_1080_TB1); // RL7
      end
      STD_SD_NTSC:
      begin
        selSd = (sdCtrl_q[SD_ODD_BIT] && timing.lineNum == LN_SD_ODD) ||
                (sdCtrl_q[SD_EVEN_BIT] && timing.lineNum == LN_SD_EVEN);  // RL22
      end
      default:
      begin
        selCm = 1'b0;
      end
    endcase
  end

  // cycles since hsync fall, saturating
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cyc_q <= 16'h0000;
    end
    else if (timing.hsyncFall)
    begin
      cyc_q <= 16'h0000;
    end
    else if (cyc_q != 16'hffff)
    begin
      cyc_q <= cyc_q + 16'h0001;
    end
  end

  // bit-rate divider, running only while sending
  assign bitEn = (state_q == S_SEND) && (bitDiv_q == 16'(BITLEN - 1));

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      bitDiv_q <= 16'h0000;
    end
    else if (state_q != S_SEND || bitEn)
    begin
      bitDiv_q <= 16'h0000;
    end
    else
    begin
      bitDiv_q <= bitDiv_q + 16'h0001;
    end
  end

  // line sequencer: lead-in, serial bits, then wss tail to video resume
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_q     <= S_IDLE;
      shift_q     <= '0;
      bitsLeft_q  <= 8'h00;
      wssLine_q   <= 1'b0;
      blankBits_q <= 1'b0;
    end
    else if (timing.hsyncFall)
    begin
      // every line start re-decides; a late line is abandoned
      wssLine_q   <= palWssLine && (selWss || sdBlank_q[WSS_BLANK_BIT]);
      blankBits_q <= palWssLine && sdBlank_q[WSS_BLANK_BIT];   // RL19
      state_q     <= S_IDLE;
      if (selTb)
      begin
        shift_q    <= tbWord;
        bitsLeft_q <= TB_BITS;
        state_q    <= S_LEAD;
      end
      else if (selCm || selSd)
      begin
        shift_q    <= 134'(selCm ? cmWord : sdWord);
        bitsLeft_q <= CM_BITS;
        state_q    <= S_LEAD;
      end
      else if (selEd)
      begin
        shift_q    <= 134'(edWord);
        bitsLeft_q <= ED_BITS;
        state_q    <= S_LEAD;
      end
      else if (palWssLine && (selWss || sdBlank_q[WSS_BLANK_BIT]))
      begin
        shift_q    <= 134'({wssWord, WSS_PREFIX});             // RL16
        bitsLeft_q <= selWss ? WSS_BITS : 8'h00;
        state_q    <= S_LEAD;
      end
    end
    else
    begin
      case (state_q)
        S_IDLE:
        begin
          state_q <= S_IDLE;
        end
        S_LEAD:
        begin
          if (cyc_q >= 16'(LEAD))
          begin
            state_q <= (bitsLeft_q == 8'h00) ? S_TAIL : S_SEND;
          end
        end
        S_SEND:
        begin
          if (bitEn)
          begin
            shift_q    <= shift_q >> 1;
            bitsLeft_q <= bitsLeft_q - 8'h01;
            if (bitsLeft_q == 8'h01)
            begin
              state_q <= wssLine_q ? S_TAIL : S_IDLE;
            end
          end
        end
        S_TAIL:
        begin
          if (cyc_q >= 16'(WSS_END))
          begin
            state_q <= S_IDLE;                                 // RL17
          end
        end
        default:
        begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  // output mux: bits at high/blank levels, lead and tail at blank, idle passes video
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      videoOut  <= LVL_BLANK;
      insActive <= 1'b0;
    end
    else
    begin
      insActive <= (state_q != S_IDLE);
      case (state_q)
        S_SEND:
        begin
          videoOut <= (shift_q[0] && !blankBits_q) ? LVL_HIGH : LVL_BLANK; // RL19
        end
        S_LEAD, S_TAIL:
        begin
          videoOut <= LVL_BLANK;
        end
        default:
        begin
          videoOut <= videoIn;                                 // RL17
        end
      endcase
    end
  end
endmodule : vbi_inserter
`default_nettype wire

/* File: sim/vbi_inserter_checker.sv */
/*
  concurrent checks on the inserter ports: line start, lead, wss window, read-back.
  assumes lines are spaced well apart and the small timing parameters.
*/
`timescale 1ns/10ps
`default_nettype none
module vbi_inserter_checker
  import vbi_pkg::*;
#(
  parameter int WSS_END = 200,
  parameter int LEAD    = 10,
  parameter int BITLEN  = 2
)(
  input wire logic       clk,
  input wire logic       rstn,
  input wire vbiRegWr_t  regWr,
  input wire logic [7:0] regRdAddr,
  input wire logic [7:0] regRdData,
  input wire vbiStd_t    videoStd,
  input wire vbiTiming_t timing,
  input wire logic [9:0] videoIn,
  input wire logic [9:0] videoOut,
  input wire logic       insActive
);
  logic [7:0]  cm_q, tb_q, sd_q, bl_q;  // shadow control registers
  logic [9:0]  cyc_q;                   // edges since line start
  logic        wss_q, blk_q, arm_q, hit, pal23;
  wire  [10:0] ln = timing.lineNum;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // shadow control writes and time the line
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      {cm_q, tb_q, sd_q, bl_q, cyc_q, wss_q, blk_q, arm_q} <= '0;
    else
    begin
      arm_q <= 1'b1;
      if (regWr.en && regWr.addr == ADDR_EDHD_CTRL) cm_q <= regWr.data;
      if (regWr.en && regWr.addr == ADDR_TB_FIRST) tb_q <= regWr.data;
      if (regWr.en && regWr.addr == ADDR_SD_CTRL) sd_q <= regWr.data;
      if (regWr.en && regWr.addr == ADDR_SD_BLANK) bl_q <= regWr.data;
      if (timing.hsyncFall)
      begin
        cyc_q <= 10'd1;
        wss_q <= pal23 && hit;
        blk_q <= bl_q[7];
      end
      else if (cyc_q != '1) cyc_q <= cyc_q + 10'd1;
    end
  // does the starting line carry an insertion
  always_comb
  begin
    pal23 = videoStd == STD_SD_PAL && ln == LN_WSS;
    case (videoStd)
      STD_ED_625P:  hit = ln == LN_ED625_CM && cm_q[6];
      STD_HD_720P:  hit = (ln == LN_720_CM && cm_q[6]) || (ln == LN_720_TB && tb_q[0]);
      STD_HD_1080I: hit = ((ln == 19 || ln == 582) && cm_q[6]) || ((ln == 18 || ln == 581) && tb_q[0]);
      STD_SD_PAL:   hit = pal23 && (sd_q[7] || bl_q[7]);
      STD_SD_NTSC:  hit = (ln == LN_SD_ODD && sd_q[5]) || (ln == LN_SD_EVEN && sd_q[6]);
      default:      hit = 1'b0;
    endcase
  end
  AST_LINE_START: assert property (timing.hsyncFall && hit |-> ##3 insActive)
    else $error("insertion window did not open");
  AST_LINE_NONE: assert property (timing.hsyncFall && !hit && videoStd != STD_ED_525P |-> ##3 !insActive)
    else $error("insertion on a line that carries none");
  AST_LEAD_BLANK: assert property ($rose(insActive) |-> (videoOut == LVL_BLANK) [*8])
    else $error("lead of the line not at blank level");
  AST_IDLE_VIDEO: assert property (arm_q && !insActive |-> videoOut == $past(videoIn))
    else $error("video not passed through when idle");
  AST_WSS_BLANKED: assert property (wss_q && blk_q && cyc_q inside {[3:WSS_END-1]} |-> videoOut == LVL_BLANK)
    else $error("blanked wide-screen portion shows data");
  AST_WSS_TAIL: assert property (wss_q && cyc_q inside {[LEAD+3+38*BITLEN:WSS_END-1]} |-> videoOut == LVL_BLANK)
    else $error("wide-screen tail not blank");
  AST_WSS_RESUME: assert property (wss_q && cyc_q inside {[WSS_END+3:WSS_END+60]} |-> videoOut == $past(videoIn))
    else $error("video did not resume after the wide-screen part");
  AST_RD_CTRL: assert property (regRdAddr == ADDR_EDHD_CTRL && !regWr.en |=> regRdData == $past(cm_q))
    else $error("control read-back wrong");
  cover property (timing.hsyncFall && hit && videoStd == STD_HD_720P);
  cover property (wss_q && cyc_q == WSS_END);
  cover property ($fell(insActive));
endmodule : vbi_inserter_checker
bind vbi_inserter vbi_inserter_checker #(.WSS_END(WSS_END), .LEAD(LEAD), .BITLEN(BITLEN)) chk_u (
  .clk(clk), .rstn(rstn), .regWr(regWr), .regRdAddr(regRdAddr), .regRdData(regRdData),
  .videoStd(videoStd), .timing(timing), .videoIn(videoIn), .videoOut(videoOut), .insActive(insActive));
`default_nettype wire

/* File: sim/vbi_tv_sink.sv */
/*
  receiver model: slices inserted bits from the video output mid-bit.
  assumes the lead and bit length that the inserter is built with.
*/
`timescale 1ns/10ps
`default_nettype none
module vbi_tv_sink
  import vbi_pkg::*;
#(
  parameter int LEAD   = 10,
  parameter int BITLEN = 2
)(
  input  wire logic [9:0] video,
  input  wire logic       active,
  input  wire logic       clk,
  input  wire logic       rstn,
  output logic [133:0]    bits,
  output logic [7:0]      cnt
);
  logic       prev_q;  // window seen last edge
  logic [9:0] cyc_q;   // edges since window opened
  // restart on a new window, slice each bit lsb first
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      {prev_q, cyc_q, bits, cnt} <= '0;
    else
    begin
      prev_q <= active;
      if (active && !prev_q)
        {cyc_q, bits, cnt} <= {10'd1, 134'd0, 8'd0};
      else
      begin
        cyc_q <= cyc_q + 10'd1;
        if (active && cyc_q >= LEAD + BITLEN / 2 && (cyc_q - LEAD - BITLEN / 2) % BITLEN == 0 && cnt < 134)
        begin
          bits[cnt] <= video == LVL_HIGH;
          cnt       <= cnt + 8'd1;
        end
      end
    end
endmodule : vbi_tv_sink
`default_nettype wire

/* File: sim/vbi_inserter_tb.sv */
/*
  self-checking bench for the inserter with a receiver model.
  assumes small lead, bit and wss timing parameters.
*/
`timescale 1ns/10ps
`default_nettype none
module vbi_inserter_tb
  import vbi_pkg::*;
;
  logic         clk = 1'b0, rstn = 1'b0, act;
  vbiRegWr_t    regWr = '0;
  logic [7:0]   rdAddr = '0, rdData, rxCnt;
  logic [7:0]   rg [0:255];
  vbiStd_t      std = STD_SD_NTSC;
  vbiTiming_t   tim = '0;
  logic [9:0]   vin = '0, vout;
  logic [133:0] rxBits;
  // mapped subaddresses for read-back
  logic [7:0]   rbAddrs [10] = '{8'h32, 8'h41, 8'h42, 8'h43, 8'h5e, 8'h99, 8'h9a, 8'h9b, 8'ha1, 8'h6e};
  int           seed = 42558, failures = 0, num_checks = 0;
  always #4 clk = ~clk;
  always @(posedge clk) vin <= 10'($random(seed));
  vbi_inserter #(.WSS_END(200), .LEAD(10), .BITLEN(2)) dut_u (.clk(clk), .rstn(rstn), .regWr(regWr),
    .regRdAddr(rdAddr), .regRdData(rdData), .videoStd(std), .timing(tim), .videoIn(vin),
    .videoOut(vout), .insActive(act));
  vbi_tv_sink #(.LEAD(10), .BITLEN(2)) sink_u (.clk(clk), .rstn(rstn), .video(vout), .active(act),
    .bits(rxBits), .cnt(rxCnt));
  task automatic stop_test;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : stop_test
  task automatic chkv(input string nm, input logic [133:0] e, input logic [133:0] g);
    num_checks++;
    if (g !== e)
    begin
      failures++;
      $display("unexpected %s exp=%h got=%h", nm, e, g);
    end
  endtask : chkv
  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e)
    begin
      failures++;
      $display("unexpected %s exp=%h got=%h", nm, e, g);
    end
  endtask : chk8
  // one register write, strobe dropped on the next edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) regWr <= '{1'b1, a, d};
    @(posedge clk) regWr <= '{1'b0, a, d};
    rg[a] = d;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk) rdAddr <= a;
    @(posedge clk) #1 chk8("read", e, rdData);
  endtask : rd
  // x^6+x+1, all-ones preset, bit 0 first
  function automatic logic [5:0] crc(input logic [127:0] d, input int n);
    logic [5:0] c;
    c = 6'h3f;
    for (int i = 0; i < n; i++) c = {c[4:0], 1'b0} ^ ((d[i] ^ c[5]) ? 6'h03 : 6'h00);
    return c;
  endfunction : crc
  // bits the line should carry, lsb sent first
  function automatic logic [133:0] expv(input vbiStd_t s, input int ln, output int n);
    logic [133:0] v;
    logic [19:0]  w;
    logic         hd, t;
    v  = '0;
    n  = 0;
    hd = s == STD_HD_720P ? ln == 24 : s == STD_HD_1080I && (ln == 19 || ln == 582);
    t  = s == STD_HD_720P ? ln == 23 : s == STD_HD_1080I && (ln == 18 || ln == 581);
    if (s == STD_ED_625P && ln == 43 && rg[8'h32][6])
      {n, v[15:0]} = {32'd16, rg[8'h42], rg[8'h43]};
    else if (hd && rg[8'h32][6] || s == STD_SD_NTSC && (ln == 20 && rg[8'h99][5] || ln == 283 && rg[8'h99][6]))
    begin
      n = 20;
      w = hd ? {rg[8'h41][3:0], rg[8'h42], rg[8'h43]} : {rg[8'h99][3:0], rg[8'h9a], rg[8'h9b]};
      if (hd ? rg[8'h32][7] : rg[8'h99][4]) w[19:14] = crc(128'(w[13:0]), 14);
      v[19:0] = w;
    end
    else if (t && rg[8'h5e][0])
    begin
      n = 134;
      v[5:0] = rg[8'h5e][7:2];
      for (int i = 0; i < 16; i++) v[6 + 8 * i +: 8] = rg[8'h5f + i];
      if (rg[8'h5e][1]) v[133:128] = crc(v[127:0], 128);
    end
    else if (s == STD_SD_PAL && ln == 23 && (rg[8'h99][7] || rg[8'ha1][7]))
    begin
      n = 38;
      if (!rg[8'ha1][7]) v[37:0] = {rg[8'h9b][5:0], rg[8'h9a], WSS_PREFIX};
    end
    return v;
  endfunction : expv
  // random payloads, given controls, one line, then compare
  task automatic cas(input vbiStd_t s, input int ln, input logic [7:0] c32, c5e, c99, ca1);
    logic [3:0]   asp [8] = '{4'h8, 4'h1, 4'h2, 4'hb, 4'h4, 4'hd, 4'he, 4'h7};
    logic [133:0] e, m;
    logic         seen;
    int           n;
    for (int a = 8'h41; a < 8'h6f; a++) if (a < 8'h44 || a > 8'h5e) wr(8'(a), 8'($random(seed)));
    wr(8'h9a, {1'b0, 3'($random(seed)), asp[3'($random(seed))]});
    wr(8'h9b, 8'($random(seed)));
    wr(8'h32, c32);
    wr(8'h5e, {6'($random(seed)), c5e[1:0]});
    wr(8'h99, {c99[7:4], 4'($random(seed))});
    wr(8'ha1, ca1);
    @(posedge clk);
    std <= s;
    tim <= '{1'b1, 11'(ln)};
    @(posedge clk) tim.hsyncFall <= 1'b0;
    seen = 0;
    repeat (320) @(posedge clk) seen |= act;
    e = expv(s, ln, n);
    m = '1;
    m = ~(m << n);
    chkv("bits", e, rxBits & m);
    if (n == 0) chk8("window", 8'h00, 8'(seen));
    else if (n != 38) chk8("count", 8'(n), rxCnt);
  endtask : cas
  initial
  begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 10; i++)
    begin
      wr(rbAddrs[i], 8'($random(seed)));
      rd(rbAddrs[i], rg[rbAddrs[i]]);
    end
    wr(8'h6f, 8'hff);
    rd(8'h6f, 8'h00);
    repeat (2)
    begin
      cas(STD_ED_625P, 43, 8'h40, 8'h00, 8'h00, 8'h00);
      cas(STD_ED_625P, 43, 8'h00, 8'h00, 8'h00, 8'h00);
      cas(STD_HD_720P, 24, 8'h40, 8'h00, 8'h00, 8'h00);
      cas(STD_HD_720P, 24, 8'hc0, 8'h00, 8'h00, 8'h00);
      cas(STD_HD_1080I, 19, 8'hc0, 8'h00, 8'h00, 8'h00);
      cas(STD_HD_1080I, 582, 8'h40, 8'h00, 8'h00, 8'h00);
      cas(STD_HD_720P, 23, 8'h00, 8'h01, 8'h00, 8'h00);
      cas(STD_HD_720P, 23, 8'h00, 8'h03, 8'h00, 8'h00);
      cas(STD_HD_1080I, 18, 8'h00, 8'h03, 8'h00, 8'h00);
      cas(STD_HD_1080I, 581, 8'h00, 8'h01, 8'h00, 8'h00);
      cas(STD_SD_PAL, 23, 8'h00, 8'h00, 8'h80, 8'h00);
      cas(STD_SD_PAL, 23, 8'h00, 8'h00, 8'h80, 8'h80);
      cas(STD_SD_PAL, 23, 8'h00, 8'h00, 8'h00, 8'h80);
      cas(STD_SD_PAL, 23, 8'h00, 8'h00, 8'h00, 8'h00);
      cas(STD_SD_NTSC, 23, 8'h00, 8'h00, 8'h80, 8'h00);
      cas(STD_SD_PAL, 22, 8'h40, 8'h01, 8'h80, 8'h00);
      cas(STD_SD_NTSC, 20, 8'h00, 8'h00, 8'h30, 8'h00);
      cas(STD_SD_NTSC, 283, 8'h00, 8'h00, 8'h40, 8'h00);
      cas(STD_SD_NTSC, 283, 8'h00, 8'h00, 8'h20, 8'h00);
    end
    stop_test();
  end
  // cut a hang short
  initial
  begin
    repeat (40000) @(posedge clk);
    failures++;
    stop_test();
  end
endmodule : vbi_inserter_tb
`default_nettype wire
